/* File: verilog/lpm_defines.svh */
// constants for the line phase event monitor: bit positions and rates
// assumes every user includes it by bare name
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
// ==========================================================
// timebase
`define CLK_HZ 20000000
`define TB_HZ 256000
`define ACC_W 25
// ==========================================================
// register field positions
`define FLAG_DIP_BIT 16
`define FLAG_SEQ_BIT 19
`define DIP_STYLE_BIT 6
`define SEL_HI 10
`define SEL_LO 9
`define DIP_STATE_LO 12
`define DIP_STATE_HI 14
// ==========================================================
// widths
`define SPAN_W 16
`define LVL_W 24
`define HC_W 8
`endif

/* File: verilog/lpm_pkg.sv */
// types shared by the line phase event monitor files
// assumes lpm_defines.svh is on the include path
`default_nettype none
`include "lpm_defines.svh"
package lpm_pkg;
   // ==========================================================
   // delay pair selection
   typedef enum logic [1:0] {
      SEL_V_TO_I = 2'b00,
      SEL_V_TO_V = 2'b01,
      SEL_I_TO_I = 2'b10,
      SEL_RSVD = 2'b11
   } delay_pair_e;
   // ==========================================================
   // one-cycle crossing pulses from the detectors, bit 0 is phase a
   typedef struct packed {
      logic [2:0] v_rise; // voltage negative-to-positive
      logic [2:0] i_rise; // current negative-to-positive
      logic [2:0] v_any; // voltage crossing, either direction
   } zx_events_s;
   // ==========================================================
   // state of the monitor outside its span counters
   typedef struct packed {
      logic [`ACC_W-1:0] acc;
      logic tick;
      logic [1:0] last_ph;
      logic last_ok;
      logic seq_flag;
      logic dip_flag;
      logic irq_n;
      logic [2:0] dip_state;
      logic [2:0] all_below;
      logic [2:0] all_above;
      logic [2:0][`HC_W-1:0] bl_cnt;
      logic [2:0][`HC_W-1:0] ab_cnt;
   } monitor_state_s;
endpackage : lpm_pkg
`default_nettype wire

/* File: verilog/span_counter.sv */
// tick counter between a start and a stop pulse, saturating
// assumes start/stop are one-cycle pulses and tick a one-cycle enable
`default_nettype none
module span_counter #(
   parameter int W = 16
) (
   input wire logic ref_clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic tick, // timebase enable
   input wire logic start, // begin a measurement
   input wire logic stop, // end a measurement
   output logic [W-1:0] span // last measured count
);
   typedef struct packed {
      logic run;
      logic [W-1:0] cnt;
      logic [W-1:0] span;
   } span_state_s;
   span_state_s s_r;
   span_state_s s_nxt;
   // ==========================================================
   // stop is handled before start so equal pulses restart a period
   always_comb begin
      s_nxt = s_r;
      if (s_r.run && tick && s_r.cnt != '1) begin
         s_nxt.cnt = s_r.cnt + 1'b1; // saturates at all ones
      end
      if (stop && s_r.run) begin
         s_nxt.span = s_nxt.cnt;
         s_nxt.run = 1'b0;
      end
      if (start) begin
         s_nxt.run = 1'b1;
         s_nxt.cnt = '0;
      end
   end
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign span = s_r.span;
endmodule : span_counter
`default_nettype wire

/* File: verilog/line_phase_event_monitor.sv */
// line phase event monitor: phase order, delays, periods, dips
// assumes crossing pulses and voltage magnitudes are in ref_clk domain
`default_nettype none
`include "lpm_defines.svh"
module line_phase_event_monitor
   import lpm_pkg::*;
(
   input wire logic ref_clk, // 20 MHz system clock
   input wire logic srst, // sync reset, high
   input wire zx_events_s zx, // crossing pulses
   input wire logic [2:0][`LVL_W-1:0] v_abs, // filtered voltage magnitude
   input wire logic [31:0] event_enable_reg_1, // interrupt enables
   input wire logic [15:0] computation_mode_reg, // delay pair field
   input wire logic [7:0] accumulation_mode_reg, // dip style bit
   input wire logic [`LVL_W-1:0] dip_threshold_level, // dip level
   input wire logic [`HC_W-1:0] dip_half_cycle_count, // half cycles
   input wire logic dip_count_wr, // pulse: count register written
   input wire logic flag_wr, // pulse: event flag register written
   input wire logic [31:0] flag_wdata, // ones clear flags
   output logic [31:0] event_flag_reg_1, // sticky event flags
   output logic [15:0] phase_status_reg, // dip state per phase
   output logic interrupt_line_1_n, // interrupt, low active
   output logic [`SPAN_W-1:0] phase_delay_0, // delay slot 0
   output logic [`SPAN_W-1:0] phase_delay_1, // delay slot 1
   output logic [`SPAN_W-1:0] phase_delay_2, // delay slot 2
   output logic [`SPAN_W-1:0] phase_a_line_period, // phase a period
   output logic [`SPAN_W-1:0] phase_b_line_period, // phase b period
   output logic [`SPAN_W-1:0] phase_c_line_period // phase c period
);
   // ==========================================================
   // timebase constants; the ratio is not whole, so a phase
   // accumulator gives exact average rate with 78/79 cycle spacing
   localparam logic [`ACC_W-1:0] ACC_INC = `ACC_W'(`TB_HZ);
   localparam logic [`ACC_W-1:0] ACC_MOD = `ACC_W'(`CLK_HZ);

   monitor_state_s s_r;
   monitor_state_s s_nxt;
   delay_pair_e pair_sel;
   logic dip_style;
   logic [2:0] below;
   logic [2:0] d_start;
   logic [2:0] d_stop;
   logic [2:0][`SPAN_W-1:0] delay_val;
   logic [2:0][`SPAN_W-1:0] period_val;

   assign pair_sel = delay_pair_e'(computation_mode_reg[`SEL_HI:`SEL_LO]);
   assign dip_style = accumulation_mode_reg[`DIP_STYLE_BIT];

   // ==========================================================
   // per-phase level compare and span counters
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_phase
         // magnitude below level means the phase is in a dip
         assign below[gp] = v_abs[gp] < dip_threshold_level;
         span_counter #(
            .W(`SPAN_W)
         ) u_delay (
            .ref_clk(ref_clk),
            .srst(srst),
            .tick(s_r.tick),
            .start(d_start[gp]),
            .stop(d_stop[gp]),
            .span(delay_val[gp])
         );
         // period: each rising crossing ends one span and starts the next
         span_counter #(
            .W(`SPAN_W)
         ) u_period (
            .ref_clk(ref_clk),
            .srst(srst),
            .tick(s_r.tick),
            .start(zx.v_rise[gp]),
            .stop(zx.v_rise[gp]),
            .span(period_val[gp])
         );
      end
   endgenerate

   // ==========================================================
   // delay start/stop selection; only one set runs at a time
   // the reserved code behaves like 00 so the slots never freeze
   always_comb begin
      case (pair_sel)
         SEL_V_TO_V: begin
            d_start = {zx.v_rise[0], zx.v_rise[1], zx.v_rise[0]};
            d_stop = {zx.v_rise[1], zx.v_rise[2], zx.v_rise[2]};
         end
         SEL_I_TO_I: begin
            d_start = {zx.i_rise[0], zx.i_rise[1], zx.i_rise[0]};
            d_stop = {zx.i_rise[1], zx.i_rise[2], zx.i_rise[2]};
         end
         default: begin
            d_start = zx.v_rise;
            d_stop = zx.i_rise;
         end
      endcase
   end

   // ==========================================================
   // next state: timebase, order check, dip tracking, flags
   always_comb begin
      logic [1:0] ph;
      logic [1:0] prev_ph;
      logic seq_ev;
      logic dip_ev;
      logic bw;
      logic aw;
      ph = 2'b00;
      prev_ph = 2'b00;
      seq_ev = 1'b0;
      dip_ev = 1'b0;
      bw = 1'b0;
      aw = 1'b0;
      s_nxt = s_r;

      // fractional divider for the 256 kHz enable
      s_nxt.tick = 1'b0;
      s_nxt.acc = s_r.acc + ACC_INC;
      if (s_nxt.acc >= ACC_MOD) begin
         s_nxt.acc = s_nxt.acc - ACC_MOD;
         s_nxt.tick = 1'b1;
      end

      // phase order: only rising voltage crossings; if two phases
      // cross in one cycle, the lower phase is taken
      if (|zx.v_rise) begin
         if (zx.v_rise[0]) begin
            ph = 2'd0;
         end else if (zx.v_rise[1]) begin
            ph = 2'd1;
         end else begin
            ph = 2'd2;
         end
         prev_ph = (s_r.last_ph == 2'd0) ? 2'd2 : s_r.last_ph - 2'd1;
         // c after a, b after c, a after b
         seq_ev = s_r.last_ok && (ph == prev_ph);
         s_nxt.last_ph = ph;
         s_nxt.last_ok = 1'b1;
      end

      // dip tracking in whole half cycles per phase
      for (int p = 0; p < 3; p++) begin
         s_nxt.all_below[p] = s_r.all_below[p] & below[p];
         s_nxt.all_above[p] = s_r.all_above[p] & ~below[p];
         if (zx.v_any[p]) begin
            bw = s_r.all_below[p] & below[p];
            aw = s_r.all_above[p] & ~below[p];
            s_nxt.all_below[p] = 1'b1;
            s_nxt.all_above[p] = 1'b1;
            // a zero count is refused below; counters stop at all ones
            if (bw && s_r.bl_cnt[p] != '1) begin
               s_nxt.bl_cnt[p] = s_r.bl_cnt[p] + 1'b1;
            end else if (!bw) begin
               s_nxt.bl_cnt[p] = '0;
            end
            if (aw && s_r.dip_state[p] && s_r.ab_cnt[p] != '1) begin
               s_nxt.ab_cnt[p] = s_r.ab_cnt[p] + 1'b1;
            end else if (!aw || !s_r.dip_state[p]) begin
               s_nxt.ab_cnt[p] = '0;
            end
            // full count below: state set, style 0 flags each time
            if (dip_half_cycle_count != '0 &&
                s_nxt.bl_cnt[p] == dip_half_cycle_count) begin
               s_nxt.dip_state[p] = 1'b1;
               s_nxt.bl_cnt[p] = '0;
               dip_ev = dip_ev | ~dip_style;
            end
            // full count back above: state clears, style 1 flags
            if (s_r.dip_state[p] && dip_half_cycle_count != '0 &&
                s_nxt.ab_cnt[p] == dip_half_cycle_count) begin
               s_nxt.dip_state[p] = 1'b0;
               s_nxt.ab_cnt[p] = '0;
               dip_ev = dip_ev | dip_style;
            end
         end
      end

      // rewriting the count restarts every half-cycle run
      if (dip_count_wr) begin
         s_nxt.bl_cnt = '0;
         s_nxt.ab_cnt = '0;
      end

      // sticky flags: a new event wins over a same-cycle clear
      s_nxt.seq_flag = (s_r.seq_flag &
         ~(flag_wr & flag_wdata[`FLAG_SEQ_BIT])) | seq_ev;
      s_nxt.dip_flag = (s_r.dip_flag &
         ~(flag_wr & flag_wdata[`FLAG_DIP_BIT])) | dip_ev;
      // line follows the flags in the same cycle they change
      s_nxt.irq_n = ~((s_nxt.seq_flag &
         event_enable_reg_1[`FLAG_SEQ_BIT]) |
         (s_nxt.dip_flag & event_enable_reg_1[`FLAG_DIP_BIT]));
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.irq_n <= 1'b1;
         s_r.all_below <= 3'h7;
         s_r.all_above <= 3'h7;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   always_comb begin
      event_flag_reg_1 = '0;
      event_flag_reg_1[`FLAG_SEQ_BIT] = s_r.seq_flag;
      event_flag_reg_1[`FLAG_DIP_BIT] = s_r.dip_flag;
      phase_status_reg = '0;
      phase_status_reg[`DIP_STATE_HI:`DIP_STATE_LO] = s_r.dip_state;
   end
   assign interrupt_line_1_n = s_r.irq_n;
   assign phase_delay_0 = delay_val[0];
   assign phase_delay_1 = delay_val[1];
   assign phase_delay_2 = delay_val[2];
   assign phase_a_line_period = period_val[0];
   assign phase_b_line_period = period_val[1];
   assign phase_c_line_period = period_val[2];

   // ==========================================================
   // checks
   property p_seq_set;
      @(posedge ref_clk) disable iff (srst)
      (s_r.last_ok && s_r.last_ph == 2'd0 && zx.v_rise == 3'b100)
         |=> s_r.seq_flag;
   endproperty
   a_seq_set: assert property (p_seq_set)
      else $error("c after a did not flag phase order");

   property p_seq_quiet;
      @(posedge ref_clk) disable iff (srst)
      (zx.v_rise == 3'b000 && !s_r.seq_flag) |=> !s_r.seq_flag;
   endproperty
   a_seq_quiet: assert property (p_seq_quiet)
      else $error("phase order flag without rising crossing");

   property p_seq_again;
      @(posedge ref_clk) disable iff (srst)
      (s_r.last_ok && s_r.last_ph == 2'd1 && zx.v_rise == 3'b001)
         |=> s_r.seq_flag;
   endproperty
   a_seq_again: assert property (p_seq_again)
      else $error("a after b did not flag phase order");

   property p_seq_irq;
      @(posedge ref_clk) disable iff (srst)
      ($rose(s_r.seq_flag) && event_enable_reg_1[`FLAG_SEQ_BIT])
         |-> !interrupt_line_1_n;
   endproperty
   a_seq_irq: assert property (p_seq_irq)
      else $error("enabled phase order fault left line high");

   // the line uses the enable of the cycle before, hence the delay
   property p_seq_hold;
      @(posedge ref_clk) disable iff (srst)
      (s_r.seq_flag && event_enable_reg_1[`FLAG_SEQ_BIT] && !flag_wr)
         |=> !interrupt_line_1_n;
   endproperty
   a_seq_hold: assert property (p_seq_hold)
      else $error("line released while phase order fault pending");

   property p_seq_clear;
      @(posedge ref_clk) disable iff (srst)
      (flag_wr && flag_wdata[`FLAG_SEQ_BIT] && zx.v_rise == 3'b000)
         |=> !s_r.seq_flag;
   endproperty
   a_seq_clear: assert property (p_seq_clear)
      else $error("phase order flag not cleared by write");

   property p_dip_clear;
      @(posedge ref_clk) disable iff (srst)
      (flag_wr && flag_wdata[`FLAG_DIP_BIT] && zx.v_any == 3'b000)
         |=> !s_r.dip_flag;
   endproperty
   a_dip_clear: assert property (p_dip_clear)
      else $error("dip flag not cleared by write");

   property p_dip_state;
      @(posedge ref_clk) disable iff (srst)
      ($rose(s_r.dip_flag) && !dip_style) |-> $rose(|s_r.dip_state) ||
         (|(s_r.dip_state & $past(s_r.dip_state)));
   endproperty
   a_dip_state: assert property (p_dip_state)
      else $error("dip flag rose with no phase in dip");

   property p_dip_irq;
      @(posedge ref_clk) disable iff (srst)
      ($rose(s_r.dip_flag) && event_enable_reg_1[`FLAG_DIP_BIT])
         |-> !interrupt_line_1_n;
   endproperty
   a_dip_irq: assert property (p_dip_irq)
      else $error("enabled dip flag left line high");

   property p_dip_hold;
      @(posedge ref_clk) disable iff (srst)
      (s_r.dip_flag && event_enable_reg_1[`FLAG_DIP_BIT] && !flag_wr)
         |=> !interrupt_line_1_n;
   endproperty
   a_dip_hold: assert property (p_dip_hold)
      else $error("line released while dip flag pending");

   property p_idle_high;
      @(posedge ref_clk) disable iff (srst)
      (!s_r.seq_flag && !s_r.dip_flag) |-> interrupt_line_1_n;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("line low with no flag set");

   property p_tick_gap;
      @(posedge ref_clk) disable iff (srst)
      s_r.tick |=> (!s_r.tick)[*8] ##[70:71] s_r.tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("timebase tick spacing not 78 or 79 cycles");

   c_seq: cover property (@(posedge ref_clk) $rose(s_r.seq_flag));
   c_dip: cover property (@(posedge ref_clk) $rose(s_r.dip_flag));
   c_period: cover property (@(posedge ref_clk) disable iff (srst)
      $changed(phase_a_line_period));
   c_irq: cover property (@(posedge ref_clk) $fell(interrupt_line_1_n));
endmodule : line_phase_event_monitor
`default_nettype wire

/* File: bench/lpm_zx_source.sv */
// model of the crossing detectors and sensed voltage magnitudes
// assumes ref_clk domain; line period given in clock cycles
`default_nettype none
`include "lpm_defines.svh"
module lpm_zx_source
   import lpm_pkg::*;
#(
   parameter int PER = 2400
) (
   input wire logic ref_clk, // system clock
   input wire logic srst, // sync reset, high
   input wire logic rev, // reversed rotation: a, c, b
   input wire logic [15:0] lag, // current lag in cycles
   input wire logic [2:0] dip, // phases held below threshold
   output zx_events_s zx, // crossing pulses
   output logic [2:0][`LVL_W-1:0] v_abs // voltage magnitude
);
   timeunit 1ns;
   timeprecision 100ps;
   int t;
   int off;
   // ==========================================================
   // line angle in cycles; stays at zero through reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         t <= 0;
      end else begin
         t <= (t + 1) % PER;
      end
   end
   // ==========================================================
   // one-cycle pulses; silent in reset so no pulse is stuck high
   always_comb begin
      zx = '0;
      off = 0;
      for (int p = 0; p < 3; p++) begin
         off = (rev && p != 0) ? (3 - p) * PER / 3 : p * PER / 3;
         if (!srst) begin
            zx.v_rise[p] = (t == off);
            zx.i_rise[p] = (t == (off + int'(lag)) % PER);
            zx.v_any[p] = (t == off) || (t == (off + PER / 2) % PER);
         end
         v_abs[p] = dip[p] ? 24'h000100 : 24'h400000;
      end
   end
endmodule : lpm_zx_source
`default_nettype wire

/* File: bench/line_phase_event_monitor_bench.sv */
// self-checking bench for the line phase event monitor
// assumes lpm_pkg compiled first and lpm_zx_source as detector model
`default_nettype none
`include "lpm_defines.svh"
module line_phase_event_monitor_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import lpm_pkg::*;
   localparam int PER = 2400;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic rev = 1'b0;
   logic [15:0] lag = 16'h0100;
   logic [2:0] dip = 3'h0;
   zx_events_s zx;
   logic [2:0][`LVL_W-1:0] v_abs;
   logic [31:0] en = 32'h0;
   logic [15:0] cmode = 16'h0;
   logic [7:0] amode = 8'h00;
   logic [`LVL_W-1:0] lvl = 24'h100000;
   logic [`HC_W-1:0] hcc = 8'h02;
   logic dcw = 1'b0;
   logic fwr = 1'b0;
   logic [31:0] fwd = 32'h0;
   logic [31:0] flags;
   logic [15:0] pstat;
   logic irq_n;
   logic [15:0] dly [3];
   logic [15:0] per_v [3];
   logic [31:0] seed = 32'd27418;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic ok;
   // ==========================================================
   // clock, timeout
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 95000) begin
         errors++;
         finish_test();
      end
   end
   lpm_zx_source #(.PER(PER)) src (.ref_clk(ref_clk), .srst(srst),
      .rev(rev), .lag(lag), .dip(dip), .zx(zx), .v_abs(v_abs));
   line_phase_event_monitor uut (.ref_clk(ref_clk), .srst(srst),
      .zx(zx), .v_abs(v_abs), .event_enable_reg_1(en),
      .computation_mode_reg(cmode), .accumulation_mode_reg(amode),
      .dip_threshold_level(lvl), .dip_half_cycle_count(hcc),
      .dip_count_wr(dcw), .flag_wr(fwr), .flag_wdata(fwd),
      .event_flag_reg_1(flags), .phase_status_reg(pstat),
      .interrupt_line_1_n(irq_n), .phase_delay_0(dly[0]),
      .phase_delay_1(dly[1]), .phase_delay_2(dly[2]),
      .phase_a_line_period(per_v[0]), .phase_b_line_period(per_v[1]),
      .phase_c_line_period(per_v[2]));
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // tick count within one tick of the ideal, since tick phase floats
   function automatic logic near(input logic [15:0] v, input int c);
      int d;
      d = int'(v) * (`CLK_HZ / 1000) - c * (`TB_HZ / 1000);
      return (d >= -(`CLK_HZ / 1000) && d <= `CLK_HZ / 1000);
   endfunction : near
   function automatic int exp_cyc(input logic [1:0] s, input int k);
      if (s == 2'b01 || s == 2'b10) begin
         return (k == 0) ? 2 * PER / 3 : PER / 3;
      end
      return int'(lag);
   endfunction : exp_cyc
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   // park away from every voltage crossing before a clear
   task automatic sync();
      do begin
         tick(1);
      end while (src.t != 250);
   endtask : sync
   task automatic clr(input logic [31:0] d);
      fwd = d;
      fwr = 1'b1;
      tick(1);
      fwr = 1'b0;
      tick(2);
   endtask : clr
   task automatic finish_test();
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // main sequence
   initial begin
      tick(2);
      chk(flags, 32'h0);
      chk(32'(irq_n), 32'h1);
      srst = 1'b0;
      // wiring field codes 00 through 11, nonzero half-cycle count
      for (int s = 0; s < 4; s++) begin
         lag = 16'(100 + rnd() % 600);
         cmode = 16'(rnd());
         cmode[`SEL_HI:`SEL_LO] = 2'(s);
         tick(2 * PER);
         for (int k = 0; k < 3; k++) begin
            ok = near(dly[k], exp_cyc(2'(s), k));
            chk(32'(ok), 32'h1);
            chk(32'(near(per_v[k], PER)), 32'h1);
         end
         chk(flags, 32'h0);
      end
      // reversed rotation with the fault interrupt enabled
      en = 32'h0008_0000;
      rev = 1'b1;
      tick(PER);
      chk(flags, 32'h0008_0000);
      chk(32'(irq_n), 32'h0);
      sync();
      clr(rnd() & 32'hfff6_ffff);
      chk(flags, 32'h0008_0000);
      clr(32'h0008_0000);
      chk(flags, 32'h0);
      chk(32'(irq_n), 32'h1);
      tick(PER);
      chk(flags, 32'h0008_0000);
      en = 32'h0;
      tick(2);
      chk(32'(irq_n), 32'h1);
      rev = 1'b0;
      tick(PER);
      sync();
      clr(32'h0008_0000);
      tick(PER);
      chk(flags, 32'h0);
      // sag on phase a, default flag style
      en = 32'h0001_0000;
      dcw = 1'b1;
      tick(1);
      dcw = 1'b0;
      dip = 3'b001;
      tick(2 * PER);
      chk(flags, 32'h0001_0000);
      chk(32'(pstat), 32'h1000);
      chk(32'(irq_n), 32'h0);
      sync();
      clr(32'h0001_0000);
      chk(flags, 32'h0);
      chk(32'(irq_n), 32'h1);
      tick(2 * PER);
      chk(flags, 32'h0001_0000);
      chk(32'(irq_n), 32'h0);
      // sag on phase b, flag only on recovery
      amode = 8'h40;
      dip = 3'b010;
      tick(3 * PER);
      sync();
      clr(32'h0001_0000);
      tick(2 * PER);
      chk(flags, 32'h0);
      chk(32'(pstat), 32'h2000);
      dip = 3'b000;
      tick(3 * PER);
      chk(flags, 32'h0001_0000);
      chk(32'(pstat), 32'h0);
      finish_test();
   end
endmodule : line_phase_event_monitor_bench
`default_nettype wire
